// [hw/ircp_pkg.sv]
// package with register map, field layout, timing and types of the input copy rule engine
package ircp_pkg;

   // ====================================================================
   // register map (register numbers; byte address is four times the number)
   localparam logic [7:0] RULE_FIRST_IDX = 8'h5d;   // first of twelve rule registers
   localparam int RULE_COUNT = 12;
   localparam logic [7:0] INPUT_STATE_IDX = 8'h6a;  // read-only view of the input pins
   localparam logic [31:0] RULE_RESET = 32'h0;
   localparam logic [31:0] REG_RESET = 32'h0;

   // target registers, selected by target codes 1 to 6
   localparam logic [7:0] MODE_REG_IDX = 8'h02;
   localparam logic [7:0] VELOCITY_SETPOINT_IDX = 8'h05;
   localparam logic [7:0] POSITION_SETPOINT_IDX = 8'h03;
   localparam logic [7:0] ACCELERATION_SETPOINT_IDX = 8'h06;
   localparam logic [7:0] TORQUE_SETPOINT_IDX = 8'h07;
   localparam logic [7:0] IN_POSITION_WINDOW_IDX = 8'h21;

   // source groups: index 1 selects the group base, index n selects base + n - 1
   localparam logic [7:0] MODE_PRESET_BASE = 8'h59;
   localparam logic [7:0] VELOCITY_PRESET_BASE = 8'h90;
   localparam logic [7:0] POSITION_PRESET_BASE = 8'h31;
   localparam logic [7:0] ACCELERATION_PRESET_BASE = 8'h98;
   localparam logic [7:0] TORQUE_PRESET_BASE = 8'ha0;
   localparam logic [7:0] WINDOW_PRESET_BASE = 8'ha8;
   localparam logic [7:0] GROUP_SIZE = 8'h08;
   localparam logic [7:0] ABS_REG_MAX = 8'hfe;

   // rule register field positions
   localparam int DEST_LSB = 24;
   localparam int SRC_HIGH_LSB = 16;
   localparam int SRC_LOW_LSB = 8;
   localparam int INPUT_SEL_LSB = 4;
   localparam int TARGET_LSB = 0;

   // target selection codes
   localparam logic [3:0] TGT_NONE = 4'h0;
   localparam logic [3:0] TGT_MODE = 4'h1;
   localparam logic [3:0] TGT_VELOCITY = 4'h2;
   localparam logic [3:0] TGT_POSITION = 4'h3;
   localparam logic [3:0] TGT_ACCEL = 4'h4;
   localparam logic [3:0] TGT_TORQUE = 4'h5;
   localparam logic [3:0] TGT_WINDOW = 4'h6;
   localparam logic [3:0] TGT_REGISTER = 4'h7;

   // ====================================================================
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int PASS_PERIOD_NS = 1300000;
   localparam int PASS_PERIOD_CYCLES = PASS_PERIOD_NS / CLK_PERIOD_NS;

   // ====================================================================
   // types
   typedef struct packed {
      logic [7:0] dest;
      logic [7:0] src_high;
      logic [7:0] src_low;
      logic [3:0] input_sel;
      logic [3:0] target;
   } ircp_rule_type;

   typedef struct packed {
      logic en;
      logic [7:0] src;
      logic [7:0] dst;
   } ircp_copy_type;

   typedef struct packed {
      logic valid;
      logic [7:0] dst;
      logic [31:0] data;
   } ircp_write_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ircp_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ircp_apb_rsp_type;

   typedef enum logic {ST_IDLE, ST_RUN} ircp_state_type;

   // ====================================================================
   // target register for codes 1 to 6
   function automatic logic [7:0] ircp_target_reg(input logic [3:0] code);
      logic [7:0] r;
      r = MODE_REG_IDX;
      unique case (code)
         TGT_VELOCITY: r = VELOCITY_SETPOINT_IDX;
         TGT_POSITION: r = POSITION_SETPOINT_IDX;
         TGT_ACCEL: r = ACCELERATION_SETPOINT_IDX;
         TGT_TORQUE: r = TORQUE_SETPOINT_IDX;
         TGT_WINDOW: r = IN_POSITION_WINDOW_IDX;
         default: r = MODE_REG_IDX;
      endcase
      return r;
   endfunction

   // source group base for codes 1 to 6
   function automatic logic [7:0] ircp_group_base(input logic [3:0] code);
      logic [7:0] r;
      r = MODE_PRESET_BASE;
      unique case (code)
         TGT_VELOCITY: r = VELOCITY_PRESET_BASE;
         TGT_POSITION: r = POSITION_PRESET_BASE;
         TGT_ACCEL: r = ACCELERATION_PRESET_BASE;
         TGT_TORQUE: r = TORQUE_PRESET_BASE;
         TGT_WINDOW: r = WINDOW_PRESET_BASE;
         default: r = MODE_PRESET_BASE;
      endcase
      return r;
   endfunction

endpackage

// [hw/ircp_rule_eval.sv]
// decoder that turns one copy rule and the input state into a register copy
`timescale 1ns/10ps
module ircp_rule_eval (
   input wire ircp_pkg::ircp_rule_type rule,
   input wire logic [15:0] input_state,
   output ircp_pkg::ircp_copy_type copy
);
   import ircp_pkg::*;

   logic sampled_input_level;
   logic [7:0] field;

   // ====================================================================
   // source field choice by the sampled input level
   assign sampled_input_level = input_state[rule.input_sel];
   assign field = sampled_input_level ? rule.src_high : rule.src_low;

   // ====================================================================
   // source and destination by target code
   always_comb begin
      copy = '0;
      unique case (rule.target)
         TGT_MODE, TGT_VELOCITY, TGT_POSITION, TGT_ACCEL, TGT_TORQUE, TGT_WINDOW: begin
            // field is an index into the target's own group
            copy.en = (field != 8'h00) && (field <= GROUP_SIZE);
            copy.src = ircp_group_base(rule.target) + field - 8'h01;
            copy.dst = ircp_target_reg(rule.target);
         end
         TGT_REGISTER: begin
            // absolute register numbers 1 to 254
            copy.en = (field != 8'h00) && (field <= ABS_REG_MAX)
               && (rule.dest != 8'h00) && (rule.dest <= ABS_REG_MAX);
            copy.src = field;
            copy.dst = rule.dest;
         end
         default: copy = '0; // code 0 and 8 to 15 copy nothing
      endcase
   end

endmodule

// [hw/ircp_engine.sv]
// periodic input driven register copier with apb register file
`timescale 1ns/10ps
module ircp_engine #(
   parameter int TICK_CYCLES = ircp_pkg::PASS_PERIOD_CYCLES
) (
   input wire logic clk,
   input wire logic reset,
   input wire ircp_pkg::ircp_apb_req_type apb_req,
   output ircp_pkg::ircp_apb_rsp_type apb_rsp,
   input wire logic [15:0] input_pins,
   output ircp_pkg::ircp_write_type copy_write,
   output logic busy,
   output logic pass_done
);
   import ircp_pkg::*;

   logic [31:0] regs [256];
   ircp_state_type state;
   logic [3:0] rule_idx;
   logic [17:0] tick_count;
   logic tick;
   logic tick_pending;
   logic start;
   logic [15:0] input_state;
   logic ack;
   logic err;
   logic [31:0] rdata;
   logic access;
   logic [7:0] rule_reg;
   ircp_rule_type rule;
   ircp_copy_type copy;
   logic do_copy;

   // address check: aligned and inside the 256 word window
   function automatic logic addr_ok(input logic [11:0] a);
      return (a[11:10] == 2'h0) && (a[1:0] == 2'h0);
   endfunction

   // ====================================================================
   // pass timer
   assign tick = (tick_count == 18'(TICK_CYCLES - 1));

   // free running period counter
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tick_count <= '0;
      end else if (tick) begin
         tick_count <= '0;
      end else begin
         tick_count <= tick_count + 18'h1;
      end
   end

   // pass request waits for a quiet bus; a new tick wins over the clear
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tick_pending <= 1'b0;
      end else begin
         tick_pending <= tick | (tick_pending & ~start);
      end
   end

   // ====================================================================
   // pass sequencer
   assign start = tick_pending && (state == ST_IDLE) && !apb_req.psel && !ack;
   assign busy = (state == ST_RUN);

   // one rule per cycle, rule 0 up to rule 11
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         rule_idx <= '0;
         pass_done <= 1'b0;
      end else begin
         pass_done <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               rule_idx <= '0;
               if (start) begin
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (rule_idx == 4'(RULE_COUNT - 1)) begin
                  state <= ST_IDLE;
                  pass_done <= 1'b1;
               end else begin
                  rule_idx <= rule_idx + 4'h1;
               end
            end
         endcase
      end
   end

   // input levels frozen for the whole pass
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         input_state <= '0;
      end else if (!busy) begin
         input_state <= input_pins;
      end
   end

   // ====================================================================
   // rule evaluation
   assign rule_reg = RULE_FIRST_IDX + {4'h0, rule_idx};
   assign rule = ircp_rule_type'(regs[rule_reg]);
   assign do_copy = busy && copy.en;

   ircp_rule_eval u_eval (
      .rule(rule),
      .input_state(input_state),
      .copy(copy)
   );

   // copy strobe toward the motor register file
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         copy_write <= '0;
      end else begin
         copy_write.valid <= do_copy;
         copy_write.dst <= copy.dst;
         copy_write.data <= regs[copy.src];
      end
   end

   // ====================================================================
   // apb slave: answer in the second access cycle, stalled during a pass
   assign access = apb_req.psel && apb_req.penable;
   assign apb_rsp.prdata = rdata;
   assign apb_rsp.pready = ack;
   assign apb_rsp.pslverr = ack && err;

   // access acknowledge and read capture
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ack <= 1'b0;
         err <= 1'b0;
         rdata <= '0;
      end else begin
         ack <= access && !ack && !busy;
         err <= !addr_ok(apb_req.paddr);
         if (access && !ack && !busy) begin
            rdata <= addr_ok(apb_req.paddr) ? regs[apb_req.paddr[9:2]] : 32'h0;
         end
      end
   end

   // register file: bus writes when idle, rule copies during a pass
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 256; i++) begin
            regs[i] <= REG_RESET;
         end
      end else begin
         regs[INPUT_STATE_IDX] <= {16'h0, input_state};
         if (do_copy && copy.dst != INPUT_STATE_IDX) begin
            regs[copy.dst] <= regs[copy.src];
         end else if (ack && apb_req.pwrite && addr_ok(apb_req.paddr)
                      && apb_req.paddr[9:2] != INPUT_STATE_IDX) begin
            regs[apb_req.paddr[9:2]] <= apb_req.pwdata;
         end
      end
   end

   // ====================================================================
   // checks
   property no_action_p;
      @(posedge clk) disable iff (reset)
         busy && (rule.target == TGT_NONE || rule.target > TGT_REGISTER) |-> !do_copy;
   endproperty
   no_action_a: assert property (no_action_p)
      else $error("copy issued for a no action target code");

   dest_reg_a: assert property (@(posedge clk) disable iff (reset)
      do_copy && rule.target == TGT_REGISTER |-> copy.dst == rule.dest)
      else $error("register target not taken from top byte");

   high_source_a: assert property (@(posedge clk) disable iff (reset)
      do_copy && rule.target == TGT_REGISTER && input_state[rule.input_sel]
      |-> copy.src == rule.src_high)
      else $error("high level source mismatch");

   low_source_a: assert property (@(posedge clk) disable iff (reset)
      do_copy && rule.target == TGT_REGISTER && !input_state[rule.input_sel]
      |-> copy.src == rule.src_low)
      else $error("low level source mismatch");

   zero_source_a: assert property (@(posedge clk) disable iff (reset)
      busy && (input_state[rule.input_sel] ? rule.src_high : rule.src_low) == 8'h00
      |-> !do_copy)
      else $error("zero source field produced a copy");

   position_group_a: assert property (@(posedge clk) disable iff (reset)
      do_copy && rule.target == TGT_POSITION
      |-> copy.dst == POSITION_SETPOINT_IDX && copy.src >= POSITION_PRESET_BASE
          && copy.src < POSITION_PRESET_BASE + GROUP_SIZE)
      else $error("position copy outside preset group");

   pass_length_a: assert property (@(posedge clk) disable iff (reset)
      start |=> busy [*8] ##1 busy [*4] ##1 pass_done && !busy)
      else $error("pass did not run twelve rules");

   atomic_pass_a: assert property (@(posedge clk) disable iff (reset)
      busy |-> !apb_rsp.pready)
      else $error("bus answered during a pass");

   copy_lands_a: assert property (@(posedge clk) disable iff (reset)
      do_copy && copy.dst != INPUT_STATE_IDX
      |=> copy_write.valid && regs[copy_write.dst] == copy_write.data)
      else $error("rule copy not written");

   // pass request, rule order and pass end pulse
   tick_request_a: assert property (@(posedge clk) disable iff (reset)
      tick |=> tick_pending)
      else $error("tick did not raise a pass request");

   first_rule_a: assert property (@(posedge clk) disable iff (reset)
      start |=> busy && rule_idx == 4'h0)
      else $error("pass did not begin with rule zero");

   rule_order_a: assert property (@(posedge clk) disable iff (reset)
      busy && rule_idx != 4'(RULE_COUNT - 1)
      |=> busy && rule_idx == $past(rule_idx) + 4'h1)
      else $error("rules not evaluated in ascending order");

   done_pulse_a: assert property (@(posedge clk) disable iff (reset)
      pass_done |-> !busy ##1 !pass_done)
      else $error("pass end pulse longer than one cycle");

   // input snapshot: frozen in a pass, refreshed between passes; copy strobe only in the cycle after a busy cycle
   frozen_inputs_a: assert property (@(posedge clk) disable iff (reset)
      busy |=> $stable(input_state))
      else $error("input levels changed inside a pass");

   input_follow_a: assert property (@(posedge clk) disable iff (reset)
      !busy |=> input_state == $past(input_pins))
      else $error("input levels not sampled between passes");

   copy_window_a: assert property (@(posedge clk) disable iff (reset)
      copy_write.valid |-> $past(busy))
      else $error("copy strobe outside a pass");

   // source and destination ranges per target code
   abs_range_a: assert property (@(posedge clk) disable iff (reset)
      do_copy && rule.target == TGT_REGISTER
      |-> copy.src != 8'h00 && copy.src != 8'hff && copy.dst != 8'h00 && copy.dst != 8'hff)
      else $error("register copy outside numbers 1 to 254");

   mode_group_a: assert property (@(posedge clk) disable iff (reset)
      do_copy && rule.target == TGT_MODE
      |-> copy.dst == MODE_REG_IDX && copy.src >= MODE_PRESET_BASE
          && copy.src < MODE_PRESET_BASE + GROUP_SIZE)
      else $error("mode copy outside its preset group");

   index_pick_a: assert property (@(posedge clk) disable iff (reset)
      do_copy && rule.target == TGT_POSITION && input_state[rule.input_sel]
      |-> copy.src == POSITION_PRESET_BASE + rule.src_high - 8'h01)
      else $error("position index not taken from the high field");

   // bus answer shape
   answer_pulse_a: assert property (@(posedge clk) disable iff (reset)
      apb_rsp.pready |=> !apb_rsp.pready)
      else $error("bus answer held longer than one cycle");

   unmapped_error_a: assert property (@(posedge clk) disable iff (reset)
      apb_rsp.pready |-> apb_rsp.pslverr == !addr_ok(apb_req.paddr))
      else $error("error response does not match the address");

   // ====================================================================
   // cover points for the main scenarios
   pass_cover_c: cover property (@(posedge clk) disable iff (reset) pass_done);
   low_copy_c: cover property (@(posedge clk) disable iff (reset)
      do_copy && !input_state[rule.input_sel]);
   bus_stall_c: cover property (@(posedge clk) disable iff (reset) access && busy);
   high_copy_c: cover property (@(posedge clk) disable iff (reset)
      do_copy && input_state[rule.input_sel]);
   reg_target_c: cover property (@(posedge clk) disable iff (reset)
      do_copy && rule.target == TGT_REGISTER);

endmodule

// [verif/ircp_far_model.sv]
// far side model: input pin driver and copy monitor for the engine's register writes
`timescale 1ns/10ps
module ircp_far_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] level,
   input wire logic busy,
   input wire ircp_pkg::ircp_write_type copy_write,
   output logic [15:0] input_pins,
   output logic [7:0] copy_cnt,
   output logic [7:0] last_dst,
   output logic [31:0] last_data
);
   import ircp_pkg::*;

   logic busy_q;

   // ==========================================================================
   // pins follow the requested levels one clock later, like a synchronous driver
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         input_pins <= 16'h0;
      end else begin
         input_pins <= level;
      end
   end

   // copies are counted per pass; the count restarts when busy rises
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         busy_q <= 1'h0;
         copy_cnt <= 8'h0;
         last_dst <= 8'h0;
         last_data <= 32'h0;
      end else begin
         busy_q <= busy;
         if (busy && !busy_q) begin
            copy_cnt <= 8'h0;
         end else if (copy_write.valid) begin
            copy_cnt <= copy_cnt + 8'h1;
            last_dst <= copy_write.dst;
            last_data <= copy_write.data;
         end
      end
   end
endmodule

// [verif/input_driven_register_copier_bench.sv]
// self-checking bench for the periodic input driven register copier
`timescale 1ns/10ps
module input_driven_register_copier_bench;
   import ircp_pkg::*;

   // ==========================================================================
   // rows: rule word, input levels, copies per pass, destination, source
   typedef struct packed {
      logic [31:0] rule;
      logic [15:0] lvl;
      logic [7:0] cnt;
      logic [7:0] dst;
      logic [7:0] src;
   } ircp_row_type;

   localparam int TICK = 40;
   localparam int LIMIT = 20000;
   logic clk = 1'h0;
   logic reset = 1'h1;
   ircp_apb_req_type req = '0;
   ircp_apb_rsp_type rsp;
   ircp_write_type copy_write;
   logic busy;
   logic pass_done;
   logic [15:0] level = 16'h5a3c;
   logic [15:0] input_pins;
   logic [7:0] copy_cnt;
   logic [7:0] last_dst;
   logic [31:0] last_data;
   logic [31:0] rd;
   logic err;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [7:0] srcs [11] = '{8'h31, 8'h32, 8'h38, 8'h59, 8'h5a, 8'h92, 8'h98, 8'ha3, 8'haf,
                             8'hfe, 8'h01};
   ircp_row_type rows [15] = '{
      {32'h0001_0223, 16'h0004, 8'h1, 8'h03, 8'h31},
      {32'h0001_0223, 16'h0000, 8'h1, 8'h03, 8'h32},
      {32'h0008_00f3, 16'h8000, 8'h1, 8'h03, 8'h38},
      {32'h0008_00f3, 16'h0000, 8'h0, 8'h00, 8'h00},
      {32'h0002_0001, 16'h0001, 8'h1, 8'h02, 8'h5a},
      {32'h0003_0012, 16'h0002, 8'h1, 8'h05, 8'h92},
      {32'h0001_0004, 16'h0001, 8'h1, 8'h06, 8'h98},
      {32'h0000_0405, 16'h0000, 8'h1, 8'h07, 8'ha3},
      {32'h0000_0806, 16'h0000, 8'h1, 8'h21, 8'haf},
      {32'h40fe_0107, 16'h0001, 8'h1, 8'h40, 8'hfe},
      {32'h40fe_0107, 16'h0000, 8'h1, 8'h40, 8'h01},
      {32'h4001_0100, 16'h0000, 8'h0, 8'h00, 8'h00},
      {32'h4001_0108, 16'h0000, 8'h0, 8'h00, 8'h00},
      {32'h4001_010f, 16'h0000, 8'h0, 8'h00, 8'h00},
      {32'h4001_0103, 16'h0000, 8'h1, 8'h03, 8'h31}};

   ircp_engine #(.TICK_CYCLES(TICK)) ircp_engine_i (.clk(clk), .reset(reset), .apb_req(req),
      .apb_rsp(rsp), .input_pins(input_pins), .copy_write(copy_write), .busy(busy),
      .pass_done(pass_done));

   ircp_far_model ircp_far_model_i (.clk(clk), .reset(reset), .level(level), .busy(busy),
      .copy_write(copy_write), .input_pins(input_pins), .copy_cnt(copy_cnt),
      .last_dst(last_dst), .last_data(last_data));

   // ==========================================================================
   // clock and hang guard
   always #5 clk = ~clk;

   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_count++;
         summarize();
      end
   end

   // ==========================================================================
   // shared tasks
   function automatic logic [11:0] ra(input logic [7:0] idx);
      return {2'h0, idx, 2'h0};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // one apb transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      req.psel <= 1'h1;
      req.penable <= 1'h0;
      req.pwrite <= wr;
      req.paddr <= a;
      req.pwdata <= wd;
      @(posedge clk);
      req.penable <= 1'h1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.pready !== 1'h1 && n < 100);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'h0;
      req.penable <= 1'h0;
      if (n >= 100) begin
         err_count++;
         summarize();
      end
   endtask

   // lets two passes end so the counted one began after the setup
   task automatic passes();
      int n;
      repeat (2) begin
         n = 0;
         do begin
            @(posedge clk);
            n++;
         end while (pass_done !== 1'h1 && n < 200);
         if (n >= 200) begin
            err_count++;
            summarize();
         end
      end
      @(posedge clk);
   endtask

   // measures one pass: busy length and the end pulse right after it
   task automatic busy_len();
      int n;
      int len;
      n = 0;
      len = 0;
      do begin
         @(posedge clk);
         n++;
      end while (busy !== 1'h1 && n < 200);
      while (busy === 1'h1 && len < 20) begin
         @(posedge clk);
         len++;
      end
      check(32'(len), 32'(RULE_COUNT));
      check({31'h0, pass_done}, 32'h1);
   endtask

   // ==========================================================================
   // main sequence
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'h0;
      apb(1'h0, ra(RULE_FIRST_IDX), 32'h0);
      check(rd, RULE_RESET);
      apb(1'h0, ra(INPUT_STATE_IDX), 32'h0);
      check(rd, {16'h0, level});
      apb(1'h0, 12'h800, 32'h0);
      check({31'h0, err}, 32'h1);
      $display("test reset done");
      foreach (srcs[i]) apb(1'h1, ra(srcs[i]), {16'hc0de, 8'h00, srcs[i]});
      foreach (rows[i]) begin
         apb(1'h1, ra(RULE_FIRST_IDX), rows[i].rule);
         level <= rows[i].lvl;
         passes();
         check({24'h0, copy_cnt}, {24'h0, rows[i].cnt});
         if (rows[i].cnt != 8'h0) begin
            check({24'h0, last_dst}, {24'h0, rows[i].dst});
            check(last_data, {16'hc0de, 8'h00, rows[i].src});
            apb(1'h0, ra(rows[i].dst), 32'h0);
            check(rd, {16'hc0de, 8'h00, rows[i].src});
         end
         $display("test row %0d done", i);
      end
      // first and last rule share input 0 and the mode register; the later one stays
      apb(1'h1, ra(RULE_FIRST_IDX), 32'h0001_0001);
      apb(1'h1, ra(RULE_FIRST_IDX + 8'h0b), 32'h0002_0001);
      level <= 16'h0001;
      passes();
      check({24'h0, copy_cnt}, 32'h2);
      check(last_data, 32'hc0de_005a);
      apb(1'h0, ra(MODE_REG_IDX), 32'h0);
      check(rd, 32'hc0de_005a);
      $display("test priority done");
      // reset in mid-run clears rules and targets; passes resume with no copies
      busy_len();
      @(posedge clk);
      reset <= 1'h1;
      repeat (2) @(posedge clk);
      reset <= 1'h0;
      check({30'h0, busy, pass_done}, 32'h0);
      check({24'h0, copy_cnt}, 32'h0);
      apb(1'h0, ra(MODE_REG_IDX), 32'h0);
      check(rd, REG_RESET);
      apb(1'h0, ra(RULE_FIRST_IDX + 8'h0b), 32'h0);
      check(rd, RULE_RESET);
      busy_len();
      check({24'h0, copy_cnt}, 32'h0);
      $display("test mid reset done");
      summarize();
   end
endmodule
